// [hw/ccsr_charger_regs.sv]
/*
  Charger state machine, charge timers, region current selection and limit alert register.
  Assumes the serial port logic on ref_clk_i presents one-cycle read and write strobes with
  a command code; analog comparator flags arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
module ccsr_charger_regs import ccsr_pkg::*; #(
  parameter int unsigned SECOND_CYCLES_P = SECOND_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] max_charge_time_i,
  input wire logic [15:0] const_voltage_time_limit_i,
  input wire logic [15:0] alert_enable_i,
  input wire logic [2:0] temp_region_i,
  input wire logic [4:0] base_code_i,
  input wire logic suspend_i,
  input wire logic bat_present_i,
  input wire logic bat_short_i,
  input wire logic detect_fail_i,
  input wire logic detect_done_i,
  input wire logic precharge_done_i,
  input wire logic cv_phase_i,
  input wire logic cx_reached_i,
  input wire logic temp_fault_i,
  input wire logic telemetry_ready_i,
  input wire logic [5:0] regulation_i,
  input wire logic [14:0] limit_event_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic [5:0] battery_sense_resistor_mv_o,
  output logic charging_o
);
  localparam int unsigned SYNC_W = 31;

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic suspend_s, present_s, short_s, dfail_s, ddone_s, pdone_s;
  logic cv_s, cx_s, tfault_s, telem_s;
  logic [5:0] regulation_s;
  logic [14:0] event_s;
  logic [14:0] icharge;
  logic [2:0] config_bits;
  logic [15:0] charge_minutes;
  logic [15:0] cv_seconds;
  logic [12:0] phase_word;
  logic [5:0] regulation_word;
  logic [15:0] alerts;
  logic [15:0] next_alerts;
  logic [15:0] alert_set;
  logic [15:0] alert_clr;
  ccsr_state_t state;
  ccsr_state_t next_state;
  logic [25:0] tick_cnt;
  logic sec_tick;
  logic [5:0] min_sec_cnt;
  logic cv_run;
  logic cv_run_q;
  logic cycle_start;
  logic charging_st;
  logic maxt_hit, cvt_hit, cx_hit;
  logic [4:0] active_code;
  logic [5:0] next_regulation;
  logic wr_alerts;

  // Two-flop synchronisers; suspend resets high so no false detection follows reset.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= {{(SYNC_W-1){1'b0}}, 1'b1};
      sync_b <= {{(SYNC_W-1){1'b0}}, 1'b1};
    end else if (ce_i) begin
      sync_a <= {limit_event_i, regulation_i, telemetry_ready_i, temp_fault_i, cx_reached_i,
                 cv_phase_i, precharge_done_i, detect_done_i, detect_fail_i, bat_short_i,
                 bat_present_i, suspend_i};
      sync_b <= sync_a;
    end
  end

  assign {event_s, regulation_s, telem_s, tfault_s, cx_s, cv_s, pdone_s, ddone_s, dfail_s,
          short_s, present_s, suspend_s} = sync_b;

  assign wr_alerts = reg_wr_i && (reg_addr_i == OFS_ALERTS);

  // Writable settings: region current codes and configuration bits.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      icharge <= ICHARGE_RST;
      config_bits <= CONFIG_RST;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == OFS_ICHARGE) begin
        icharge <= reg_wdata_i[14:0];
      end else if (reg_addr_i == OFS_CONFIG) begin
        // RQ5 config register write
        config_bits <= reg_wdata_i[2:0];
      end
    end
  end

  // Termination conditions seen while in the main charge state.
  // RQ9 max time reached
  assign maxt_hit = (max_charge_time_i != 16'h0000) && (charge_minutes == max_charge_time_i);
  // RQ11 voltage time exceeded
  assign cvt_hit = cv_s && (cv_seconds > const_voltage_time_limit_i);
  // RQ6 C/x termination enable
  assign cx_hit = config_bits[CFG_CX_BIT] && cv_s && cx_s;

  // Charger sequencing; suspension overrides every state, faults hold until suspended.
  always_comb begin
    next_state = state;
    if (suspend_s) begin
      next_state = ST_SUSPENDED;
    end else begin
      case (state)
        ST_SUSPENDED: next_state = ST_DETECTING;
        ST_DETECTING: begin
          if (dfail_s) next_state = ST_DETECT_FAIL;
          else if (short_s) next_state = ST_SHORT;
          else if (!present_s) next_state = ST_MISSING;
          else if (ddone_s) next_state = ST_PRECHARGE;
        end
        ST_PRECHARGE: begin
          if (maxt_hit) next_state = ST_MAX_TIME;
          else if (pdone_s) next_state = ST_MAIN;
        end
        ST_MAIN: begin
          // RQ7 temperature pause gating
          if (config_bits[CFG_TEMP_BIT] && tfault_s) next_state = ST_THERM_PAUSE;
          else if (maxt_hit) next_state = ST_MAX_TIME;
          else if (cx_hit) next_state = ST_CX_TERM;
          else if (cvt_hit) next_state = ST_TIMER_TERM;
        end
        ST_THERM_PAUSE: begin
          if (!config_bits[CFG_TEMP_BIT] || !tfault_s) next_state = ST_MAIN;
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_SUSPENDED;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign cycle_start = (state == ST_DETECTING) && (next_state == ST_PRECHARGE);
  assign charging_st = (state == ST_PRECHARGE) || (state == ST_MAIN);
  assign cv_run = (state == ST_MAIN) && cv_s;

  // Free-running one-second timebase; a long count, so its length is a parameter.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= '0;
    end else if (ce_i) begin
      if (sec_tick) tick_cnt <= '0;
      else tick_cnt <= tick_cnt + 26'h0000001;
    end
  end

  assign sec_tick = (tick_cnt == 26'(SECOND_CYCLES_P - 1));

  // Charge-cycle minute timer; it holds at zero while no maximum time is set.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      charge_minutes <= '0;
      min_sec_cnt <= '0;
    end else if (ce_i) begin
      // RQ19 restart on cycle
      if (cycle_start || (max_charge_time_i == 16'h0000)) begin
        charge_minutes <= '0;
        min_sec_cnt <= '0;
      // RQ8 count elapsed minutes
      end else if (sec_tick && (charging_st || state == ST_THERM_PAUSE)) begin
        if (min_sec_cnt == 6'(MINUTE_SECONDS - 1)) begin
          min_sec_cnt <= '0;
          if (charge_minutes != 16'hFFFF) charge_minutes <= charge_minutes + 16'h0001;
        end else begin
          min_sec_cnt <= min_sec_cnt + 6'h01;
        end
      end
    end
  end

  // Constant-voltage second timer; a phase entry restarts it, saturates instead of wrapping.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cv_seconds <= '0;
      cv_run_q <= 1'b0;
    end else if (ce_i) begin
      cv_run_q <= cv_run;
      // RQ19 restart on entry
      if (cv_run && !cv_run_q) begin
        cv_seconds <= '0;
      // RQ10 count voltage seconds
      end else if (cv_run && sec_tick && (cv_seconds != 16'hFFFF)) begin
        cv_seconds <= cv_seconds + 16'h0001;
      end
    end
  end

  // Phase word is registered so each read sees exactly one bit set.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_word <= PHASE_RST;
    end else if (ce_i) begin
      // RQ12 one-hot phase encoding
      case (next_state)
        ST_DETECTING: phase_word <= PH_DETECTING;
        ST_DETECT_FAIL: phase_word <= PH_DETECT_FAIL;
        ST_PRECHARGE: phase_word <= PH_PRECHARGE;
        ST_MAIN: phase_word <= PH_MAIN;
        ST_THERM_PAUSE: phase_word <= PH_THERM_PAUSE;
        ST_TIMER_TERM: phase_word <= PH_TIMER_TERM;
        ST_CX_TERM: phase_word <= PH_CX_TERM;
        ST_MAX_TIME: phase_word <= PH_MAX_TIME;
        ST_MISSING: phase_word <= PH_MISSING;
        ST_SHORT: phase_word <= PH_SHORT;
        default: phase_word <= PH_SUSPENDED;
      endcase
    end
  end

  // Keep only the highest active regulation loop so the bits stay exclusive.
  always_comb begin
    next_regulation = '0;
    for (int i = 0; i < 6; i++) begin
      if (regulation_s[i]) next_regulation = 6'h01 << i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      regulation_word <= '0;
    end else if (ce_i) begin
      // RQ13 exclusive, charging only
      regulation_word <= ((next_state == ST_PRECHARGE) || (next_state == ST_MAIN)) ?
                         next_regulation : 6'h00;
    end
  end

  // Alert sources: telemetry valid on the top bit, limit comparators below.
  // RQ17 telemetry valid source
  // RQ14 gate by enables
  assign alert_set = {telem_s, event_s} & alert_enable_i;
  // RQ16 zero-written bits clear
  assign alert_clr = wr_alerts ? ~reg_wdata_i : 16'h0000;
  // RQ15 sticky, set beats clear
  // RQ18 disable clears alert
  assign next_alerts = ((alerts & ~alert_clr) | alert_set) & alert_enable_i;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alerts <= '0;
    end else if (ce_i) begin
      alerts <= next_alerts;
    end
  end

  // Current code for the active region while config bit 0 is set; with it clear, or outside regions 2 to 4, the base setting applies.
  always_comb begin
    active_code = base_code_i;
    if (config_bits[CFG_TEMP_BIT]) begin
      // RQ1 region 4 code
      if (temp_region_i == REGION_4) active_code = icharge[ICH4_LSB +: ICH_W];
      // RQ2 region 3 code
      else if (temp_region_i == REGION_3) active_code = icharge[ICH3_LSB +: ICH_W];
      // RQ3 region 2 code
      else if (temp_region_i == REGION_2) active_code = icharge[ICH2_LSB +: ICH_W];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      battery_sense_resistor_mv_o <= '0;
      charging_o <= 1'b0;
    end else if (ce_i) begin
      // RQ4 code plus one
      battery_sense_resistor_mv_o <= {1'b0, active_code} + 6'h01;
      charging_o <= (next_state == ST_PRECHARGE) || (next_state == ST_MAIN);
    end
  end

  // Read port: data one cycle after the strobe, unmapped codes read zero.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (!reg_rd_i) reg_rdata_o <= reg_rdata_o;
      else if (reg_addr_i == OFS_ICHARGE) reg_rdata_o <= {1'b0, icharge};
      else if (reg_addr_i == OFS_CONFIG) reg_rdata_o <= {13'h0000, config_bits};
      else if (reg_addr_i == OFS_MINUTES) reg_rdata_o <= charge_minutes;
      else if (reg_addr_i == OFS_CV_SECONDS) reg_rdata_o <= cv_seconds;
      else if (reg_addr_i == OFS_PHASE) reg_rdata_o <= {3'h0, phase_word};
      else if (reg_addr_i == OFS_REGULATION) reg_rdata_o <= {10'h000, regulation_word};
      else if (reg_addr_i == OFS_ALERTS) reg_rdata_o <= alerts;
      else reg_rdata_o <= 16'h0000;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_region4_current: assert property ( // RQ1
    ce_i && config_bits[0] && temp_region_i == REGION_4 |=>
    battery_sense_resistor_mv_o == {1'b0, $past(icharge[14:10])} + 6'h01)
    else $error("Region 4 servo target wrong.");
  a_region3_current: assert property ( // RQ2
    ce_i && config_bits[0] && temp_region_i == REGION_3 |=>
    battery_sense_resistor_mv_o == {1'b0, $past(icharge[9:5])} + 6'h01)
    else $error("Region 3 servo target wrong.");
  a_region2_current: assert property ( // RQ3
    ce_i && config_bits[0] && temp_region_i == REGION_2 |=>
    battery_sense_resistor_mv_o == {1'b0, $past(icharge[4:0])} + 6'h01)
    else $error("Region 2 servo target wrong.");
  a_config_write: assert property ( // RQ5
    ce_i && reg_wr_i && reg_addr_i == OFS_CONFIG ##1 ce_i && reg_rd_i && reg_addr_i == OFS_CONFIG
    |=> reg_rdata_o == {13'h0000, $past(reg_wdata_i[2:0], 2)})
    else $error("Configuration readback wrong.");
  a_cx_stop: assert property ( // RQ6
    ce_i && !suspend_s && state == ST_MAIN && !(config_bits[0] && tfault_s) && !maxt_hit
    && config_bits[2] && cv_s && cx_s |=> state == ST_CX_TERM ##1 !charging_o)
    else $error("C/x termination missed.");
  a_temp_off: assert property ( // RQ7
    ce_i && !config_bits[0] |=> state != ST_THERM_PAUSE)
    else $error("Thermal pause with temperature control off.");
  a_minutes_idle: assert property ( // RQ8
    ce_i && max_charge_time_i == 16'h0000 |=> charge_minutes == 16'h0000)
    else $error("Minute timer ran without a limit.");
  a_max_time_stop: assert property ( // RQ9
    ce_i && !suspend_s && state == ST_PRECHARGE && maxt_hit |=> state == ST_MAX_TIME)
    else $error("Maximum time did not stop charging.");
  a_cv_restart: assert property ( // RQ19
    ce_i && cv_run && !cv_run_q |=> cv_seconds == 16'h0000)
    else $error("Voltage timer not restarted.");
  a_cv_timeout: assert property ( // RQ11
    ce_i && !suspend_s && state == ST_MAIN && !(config_bits[0] && tfault_s) && !maxt_hit
    && !cx_hit && cvt_hit |=> phase_word == PH_TIMER_TERM)
    else $error("Voltage time limit ignored.");
  a_phase_onehot: assert property ( // RQ12
    $onehot(phase_word))
    else $error("Phase word not one-hot.");
  a_regulation_excl: assert property ( // RQ13
    $onehot0(regulation_word) && (regulation_word == 6'h00 || phase_word[7:6] != 2'b00))
    else $error("Regulation word not exclusive.");
  a_alert_masked: assert property ( // RQ14
    ce_i |=> (alerts & ~$past(alert_enable_i)) == 16'h0000)
    else $error("Disabled alert is set.");
  a_alert_sticky: assert property ( // RQ15
    ce_i && !wr_alerts |=> ($past(alerts) & $past(alert_enable_i) & ~alerts) == 16'h0000)
    else $error("Alert bit dropped without a clear.");
  a_alert_clear: assert property ( // RQ16
    ce_i && wr_alerts |=> (alerts & ~$past(alert_set) & ~$past(reg_wdata_i)) == 16'h0000)
    else $error("Zero-written alert not cleared.");
  a_telem_valid: assert property ( // RQ17
    ce_i && telem_s && alert_enable_i[15] |=> alerts[15])
    else $error("Telemetry valid alert missed.");
endmodule : ccsr_charger_regs

// [hw/ccsr_pkg.sv]
/*
  Constants, register map and state type for the charger state and status register bank.
  Assumes a 40 MHz reference clock and a host-side serial port that presents decoded accesses.
*/
// Behaviour
// RQ1 - Region 4 current code, bits 14:10, default 31.
// RQ2 - Region 3 current code, bits 9:5, default 31.
// RQ3 - Region 2 current code, bits 4:0, default 15.
// RQ4 - Servo target equals code plus one millivolts.
// RQ5 - Three-bit read/write configuration register, reset one.
// RQ6 - Config bit 2 enables C/x termination.
// RQ7 - Config bit 0 enables temperature-qualified charging.
// RQ8 - Minute timer counts while maximum time nonzero.
// RQ9 - Stop charging when minutes reach maximum time.
// RQ10 - Seconds counter runs during constant-voltage phase.
// RQ11 - Terminate when seconds exceed voltage time limit.
// RQ12 - One-hot thirteen-bit charger phase word, reset 256.
// RQ13 - Exclusive regulation bits, active only while charging.
// RQ14 - Limit alerts flag only enabled sources.
// RQ15 - Alert bits stick until cleared or disabled.
// RQ16 - Writing zero clears that bit only.
// RQ17 - Bit 15 flags telemetry data valid.
// RQ18 - Dropping telemetry enable clears its alert.
// RQ19 - Timers restart on cycle start and entry.
package ccsr_pkg;
  // Clock rate and the one-second timebase derived from it.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SECOND_TIME_S = 1;
  localparam int unsigned SECOND_CYCLES = CLK_HZ * SECOND_TIME_S;
  localparam int unsigned MINUTE_SECONDS = 60;

  // Command codes of the registers held here.
  localparam logic [7:0] OFS_ICHARGE = 8'h28;
  localparam logic [7:0] OFS_CONFIG = 8'h29;
  localparam logic [7:0] OFS_MINUTES = 8'h30;
  localparam logic [7:0] OFS_CV_SECONDS = 8'h31;
  localparam logic [7:0] OFS_PHASE = 8'h34;
  localparam logic [7:0] OFS_REGULATION = 8'h35;
  localparam logic [7:0] OFS_ALERTS = 8'h36;

  // Field layout and reset values.
  localparam int unsigned ICH_W = 5;
  localparam int unsigned ICH4_LSB = 10;
  localparam int unsigned ICH3_LSB = 5;
  localparam int unsigned ICH2_LSB = 0;
  localparam logic [14:0] ICHARGE_RST = 15'h7FEF;
  localparam logic [2:0] CONFIG_RST = 3'h1;
  localparam int unsigned CFG_CX_BIT = 2;
  localparam int unsigned CFG_TEMP_BIT = 0;
  localparam int unsigned TELEM_BIT = 15;
  localparam logic [12:0] PHASE_RST = 13'h0100;

  // Temperature region numbers.
  localparam logic [2:0] REGION_2 = 3'h2;
  localparam logic [2:0] REGION_3 = 3'h3;
  localparam logic [2:0] REGION_4 = 3'h4;

  // One-hot phase word encodings.
  localparam logic [12:0] PH_DETECT_FAIL = 13'h1000;
  localparam logic [12:0] PH_DETECTING = 13'h0800;
  localparam logic [12:0] PH_SUSPENDED = 13'h0100;
  localparam logic [12:0] PH_PRECHARGE = 13'h0080;
  localparam logic [12:0] PH_MAIN = 13'h0040;
  localparam logic [12:0] PH_THERM_PAUSE = 13'h0020;
  localparam logic [12:0] PH_TIMER_TERM = 13'h0010;
  localparam logic [12:0] PH_CX_TERM = 13'h0008;
  localparam logic [12:0] PH_MAX_TIME = 13'h0004;
  localparam logic [12:0] PH_MISSING = 13'h0002;
  localparam logic [12:0] PH_SHORT = 13'h0001;

  typedef enum logic [3:0] {
    ST_SUSPENDED, ST_DETECTING, ST_DETECT_FAIL, ST_PRECHARGE, ST_MAIN, ST_THERM_PAUSE,
    ST_TIMER_TERM, ST_CX_TERM, ST_MAX_TIME, ST_MISSING, ST_SHORT
  } ccsr_state_t;
endpackage : ccsr_pkg

// [tb/ccsr_host_model.sv]
/*
  Host controller model for the charger register port: decoded one-cycle write and read
  strobes on a shared command code. Assumes it is called from a process aligned to a
  rising edge and that the bench sequences calls one after another.
*/
`timescale 1ns/1ps
module ccsr_host_model import ccsr_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // Idle values; address and data are inverted between accesses so stale values never match.
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // One write strobe; the design takes it at the next edge, then the lines are scrambled.
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : write

  // One read strobe; the answer is registered on the same edge that takes the strobe.
  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    ok = reg_rvalid_i;
    d = reg_rdata_i;
  endtask : read

  // zero-write clear: the target bit is 0, every other bit is written as 1.
  task automatic clear_alert(input int b);
    write(OFS_ALERTS, ~(16'h0001 << b));
  endtask : clear_alert
endmodule : ccsr_host_model

// [tb/charger_state_status_regs_tb.sv]
/*
  Self-checking bench for the charger state and status register bank.
  Assumes the host model drives the register port and a four-cycle second timebase.
*/
`timescale 1ns/1ps
module charger_state_status_regs_tb import ccsr_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce = 1'b1;
  logic [15:0] max_t = 16'h0000, cv_lim = 16'h0000, alert_en = 16'h0000;
  logic [2:0] region = 3'h0;
  logic [4:0] base = 5'h00;
  logic suspend = 1'b1, present = 1'b0, shorted = 1'b0, dfail = 1'b0, ddone = 1'b0;
  logic pdone = 1'b0, cvph = 1'b0, cxr = 1'b0, tfault = 1'b0, telem = 1'b0;
  logic [5:0] regul = 6'h00;
  logic [14:0] levt = 15'h0000;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, rd, rvalid, charging;
  logic [5:0] servo;
  int n_errors = 0;
  int compares = 0;
  localparam logic [7:0] RA [0:7] = '{OFS_ICHARGE, OFS_CONFIG, OFS_MINUTES, OFS_CV_SECONDS,
                                      OFS_PHASE, OFS_REGULATION, OFS_ALERTS, 8'h50};
  localparam logic [15:0] RV [0:7] = '{16'h7FEF, 16'h0001, 16'h0000, 16'h0000,
                                       16'h0100, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [2:0] RG [0:2] = '{REGION_4, REGION_3, REGION_2};

  // Clock at 40 MHz.
  always #12.5 ref_clk_i = ~ref_clk_i;

  // A short second keeps minute counts inside a reasonable run length.
  ccsr_charger_regs #(.SECOND_CYCLES_P(4)) DUT (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .max_charge_time_i(max_t),
    .const_voltage_time_limit_i(cv_lim), .alert_enable_i(alert_en), .temp_region_i(region),
    .base_code_i(base), .suspend_i(suspend), .bat_present_i(present), .bat_short_i(shorted),
    .detect_fail_i(dfail), .detect_done_i(ddone), .precharge_done_i(pdone),
    .cv_phase_i(cvph), .cx_reached_i(cxr), .temp_fault_i(tfault),
    .telemetry_ready_i(telem), .regulation_i(regul), .limit_event_i(levt),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .battery_sense_resistor_mv_o(servo),
    .charging_o(charging)
  );

  ccsr_host_model host (
    .ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd)
  );

  // Prints the counts and the verdict; the single exit point of the run.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A read must come back with a valid strobe as well as the expected word.
  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.read(a, d, ok);
    chk({what, " rvalid"}, 16'h0001, {15'h0, ok});
    chk(what, exp, d);
  endtask : rdchk

  // Polls the phase word; running out of polls ends the run as a failure.
  task automatic poll(input string what, input logic [15:0] exp, input int bound);
    logic [15:0] d;
    logic ok;
    int i;
    i = 0;
    do begin
      host.read(OFS_PHASE, d, ok);
      i++;
    end while (d !== exp && i < bound);
    chk(what, exp, d);
    if (d !== exp) end_sim();
  endtask : poll

  // Waits for charging to stop and returns the cycles spent; a hang ends the run.
  task automatic wait_stop(input int bound, output int n);
    n = 0;
    while (charging !== 1'b0 && n < bound) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("charging stop", 16'h0000, {15'h0, charging});
    if (charging !== 1'b0) end_sim();
  endtask : wait_stop

  // Suspend, then walk detection and precharge into the main charge state.
  task automatic start_charge();
    @(posedge ref_clk_i);
    suspend <= 1'b1;
    ddone <= 1'b0;
    pdone <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    suspend <= 1'b0;
    present <= 1'b1;
    ddone <= 1'b1;
    poll("precharge", PH_PRECHARGE, 20);
    pdone <= 1'b1;
    poll("main", PH_MAIN, 20);
  endtask : start_charge

  initial begin
    logic [15:0] d;
    logic ok;
    int n;
    repeat (5) @(posedge ref_clk_i);
    chk("servo in reset", 16'h0000, {10'h0, servo});
    rstn_i <= 1'b1;
    // Reset values of every register, plus an unmapped code.
    for (int i = 0; i < 8; i++) rdchk("reset value", RA[i], RV[i]);
    // Default and written region codes drive the servo target as code plus one.
    for (int i = 0; i < 3; i++) begin
      region <= RG[i];
      repeat (3) @(posedge ref_clk_i);
      chk("servo default", (i == 2) ? 16'd16 : 16'd32, {10'h0, servo});
    end
    host.write(OFS_ICHARGE, 16'h0CEF);
    for (int i = 0; i < 3; i++) begin
      region <= RG[i];
      repeat (3) @(posedge ref_clk_i);
      chk("servo written", 16'd4 << i, {10'h0, servo});
    end
    base <= 5'h09;
    host.write(OFS_CONFIG, 16'h0000);
    rdchk("config cleared", OFS_CONFIG, 16'h0000);
    chk("servo base", 16'd10, {10'h0, servo});
    host.write(OFS_CONFIG, 16'h0001);
    host.write(OFS_PHASE, 16'h0001);
    rdchk("phase ro", OFS_PHASE, PH_SUSPENDED);
    ce <= 1'b0;
    host.write(OFS_CONFIG, 16'h0007);
    ce <= 1'b1;
    rdchk("config frozen", OFS_CONFIG, 16'h0001);
    regul <= 6'h20;
    repeat (4) @(posedge ref_clk_i);
    rdchk("regulation idle", OFS_REGULATION, 16'h0000);
    // Minute limit of two ends the cycle no earlier than fifty seconds.
    max_t <= 16'h0002;
    start_charge();
    rdchk("regulation on", OFS_REGULATION, 16'h0020);
    wait_stop(900, n);
    chk("minute span", 16'h0001, {15'h0, n >= 200});
    rdchk("minutes", OFS_MINUTES, 16'h0002);
    // Constant-voltage limit of three seconds ends at a count of four.
    max_t <= 16'h0000;
    cv_lim <= 16'h0003;
    cvph <= 1'b1;
    start_charge();
    rdchk("minutes off", OFS_MINUTES, 16'h0000);
    wait_stop(100, n);
    rdchk("cv seconds", OFS_CV_SECONDS, 16'h0004);
    // C/x termination once enabled, and the cv count restarts on entry.
    cv_lim <= 16'h0064;
    host.write(OFS_CONFIG, 16'h0005);
    start_charge();
    host.read(OFS_CV_SECONDS, d, ok);
    chk("cv restart", 16'h0001, {15'h0, d < 16'h0004});
    // A thermal fault pauses the main charge and its removal resumes it.
    tfault <= 1'b1;
    poll("thermal pause", PH_THERM_PAUSE, 20);
    tfault <= 1'b0;
    poll("pause over", PH_MAIN, 20);
    cxr <= 1'b1;
    poll("cx term", PH_CX_TERM, 20);
    // Only enabled alerts set, and they stick until cleared or disabled.
    alert_en <= 16'h8001;
    levt <= 15'h0003;
    telem <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rdchk("alerts set", OFS_ALERTS, 16'h8001);
    // Both sources drop, so only stickiness can keep the bits up.
    levt <= 15'h0000;
    telem <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rdchk("alerts held", OFS_ALERTS, 16'h8001);
    host.clear_alert(0);
    rdchk("alert cleared", OFS_ALERTS, 16'h8000);
    alert_en <= 16'h0001;
    repeat (2) @(posedge ref_clk_i);
    rdchk("alert disabled", OFS_ALERTS, 16'h0000);
    end_sim();
  end
endmodule : charger_state_status_regs_tb
